// ===== hw/ccu_top.v
// Purpose: two capture/compare channels sharing one 16-bit timer, with registers
// Assumes: one 250 MHz clock, synchronous active-low reset, pins synchronised here
// Notes: pwm codes 11xx behave as disabled; the timer counts every clock while run is set, except on a trigger clear or a timer byte write
//
// Design decision made here: strobed register access.
`include "ccu_regs.vh"

module ccu_top (
  input wire I_REF_CLK, // 250 MHz clock
  input wire I_RST_B, // synchronous reset, active low
  input wire [7:0] I_ADDR, // register byte address
  input wire [7:0] I_WDATA, // write data
  input wire I_WR, // write strobe
  input wire I_RD, // read strobe
  input wire [1:0] I_CAP_PIN, // capture pins, async
  input wire I_ADC_EN, // converter enabled, same clock
  output reg [7:0] O_RDATA, // read data, cycle after strobe
  output reg [1:0] O_CMP_PIN, // compare output latches
  output reg O_ADC_START, // conversion start pulse
  output reg [1:0] O_EVT_TRIG, // special event trigger pulses
  output reg O_IRQ // match or timer overflow interrupt, level
);

  // register map, byte offsets on the strobe port
  // 0C flag one: bit 0 timer overflow, bit 2 channel one match
  // 0D channel two flag: bit 0 match
  // 0E, 0F timer low and high bytes
  // 10 timer control: bit 0 run
  // 15, 16 channel one value pair, low and high
  // 17 channel one control, mode in bits 3-0
  // 1B, 1C channel two value pair, low and high
  // 1D channel two control, mode in bits 3-0
  // 8C enable one: bit 0 overflow, bit 2 channel one match
  // 8D channel two enable: bit 0 match
  // unmapped offsets ignore writes and read as zero
  //
  // byte pairs carry no latch: software that writes a running
  // timer one byte at a time may see a carry between the bytes,
  // so stop the timer before presetting it
  //
  // flag bits take the value written, so a zero clears;
  // a hardware set in the same cycle wins, so a clear
  // racing a match leaves the flag up and no event is lost

  reg [15:0] tmr_q;
  reg tmr_run_q;
  reg tmr_ovf_q;
  reg [7:0] flag1_rest_q; // other flag-1 bits, kept as plain storage
  reg [7:0] en1_q;
  reg [7:0] en2_q;
  reg [1:0] sync1_q;
  reg [1:0] sync2_q;
  reg [1:0] prev_q;
  wire [1:0] match_flag_q; // per-channel match flags, from channel flops
  wire [1:0] trig_q; // per-channel trigger pulses, from channel flops
  wire [1:0] trig_any;
  wire tmr_clear;
  wire [1:0] flag_wr;
  wire [1:0] flag_wval;
  wire [15:0] cap_val [0:1];
  wire [7:0] ctrl_val [0:1];
  wire [1:0] match_set;

  // capture latency: pin edge reaches sync2 in two edges, edge seen
  // the next cycle, pair and flag written on that same edge;
  // a pin pulse shorter than one clock may be missed entirely
  // because the sync stages sample only at rising edges

  // pin synchronisers, first stage read only by the second
  always @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      prev_q <= 2'h0;
    end else begin
      sync1_q <= I_CAP_PIN;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // either channel's trigger clears the shared timer; triggers
  // on both channels in one cycle make one clear, not two

  assign tmr_clear = |trig_q;
  assign trig_any = trig_q;

  // trigger sequence, cycle by cycle:
  //   c0: timer equals pair in trigger mode, flag set
  //   c1: internal trigger high, timer cleared to zero
  //   c2: trigger output pulses, plus conversion start for channel two when I_ADC_EN was high in c1
  // the clear costs a count, so the period is pair plus two;
  // software that wants an exact period must allow for that

  // shared timer; software writes it too
  always @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      tmr_q <= 16'h0000;
      tmr_run_q <= 1'b0;
      tmr_ovf_q <= 1'b0;
    end else begin
      if (I_WR && I_ADDR == `CCU_OFS_TMR_CTRL)
        tmr_run_q <= I_WDATA[`CCU_TCTRL_RUN];
      if (tmr_clear) begin
        tmr_q <= 16'h0000;
      end else if (I_WR && I_ADDR == `CCU_OFS_TMR_LOW) begin
        tmr_q[7:0] <= I_WDATA;
      end else if (I_WR && I_ADDR == `CCU_OFS_TMR_HIGH) begin
        tmr_q[15:8] <= I_WDATA;
      end else if (tmr_run_q) begin
        tmr_q <= tmr_q + 16'h0001;
      end
      // overflow set wins over software clear
      if (!tmr_clear && tmr_run_q && tmr_q == 16'hFFFF)
        tmr_ovf_q <= 1'b1;
      else if (I_WR && I_ADDR == `CCU_OFS_FLAG1)
        tmr_ovf_q <= I_WDATA[`CCU_F1_TMR_OVF];
    end
  end

  // software flag writes, decoded once and shared by both
  // channels; channel one flag lives in flag one bit 2,
  // channel two flag in its own register bit 0
  assign flag_wr[0] = I_WR && I_ADDR == `CCU_OFS_FLAG1;
  assign flag_wr[1] = I_WR && I_ADDR == `CCU_OFS_CH2_FLAG;
  assign flag_wval[0] = I_WDATA[`CCU_F1_CH1_MATCH];
  assign flag_wval[1] = I_WDATA[`CCU_F2_CH2_MATCH];

  // per-channel logic; channel one is index 0, channel two index 1
  // modes 11xx decode to nothing here: no capture, no compare,
  // pin latch held, so a channel left in such a mode is inert
  // the prescaler counts rising edges only and restarts on any
  // control write, so a mode change never inherits stale counts

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      localparam [7:0] OFS_LO = (g == 0) ? `CCU_OFS_CH1_LOW : `CCU_OFS_CH2_LOW;
      localparam [7:0] OFS_HI = (g == 0) ? `CCU_OFS_CH1_HIGH : `CCU_OFS_CH2_HIGH;
      localparam [7:0] OFS_CT = (g == 0) ? `CCU_OFS_CH1_CTRL : `CCU_OFS_CH2_CTRL;
      reg [7:0] ctrl_q;
      reg [15:0] pair_q;
      reg [3:0] pre_q;
      reg pin_q;
      reg flag_q;
      reg trg_q;
      wire [3:0] mode;
      wire rise;
      wire fall;
      wire is_cmp;
      wire hit;
      reg cap_ev;
      assign mode = ctrl_q[`CCU_MODE_MSB:`CCU_MODE_LSB];
      assign rise = sync2_q[g] && !prev_q[g];
      assign fall = !sync2_q[g] && prev_q[g];
      assign is_cmp = mode[3:2] == 2'b10;
      assign hit = is_cmp && tmr_q == pair_q;

      // a compare match lasts one timer count; with the timer
      // stopped on the pair value the match holds every cycle,
      // so set and clear modes keep re-asserting their level
      // and the trigger is held off one cycle after it fires

      // capture event selection
      always @* begin
        cap_ev = 1'b0;
        case (mode)
          `CCU_M_CAP_FALL: cap_ev = fall;
          `CCU_M_CAP_RISE: cap_ev = rise;
          `CCU_M_CAP_R4: cap_ev = rise && pre_q[1:0] == 2'h3;
          `CCU_M_CAP_R16: cap_ev = rise && pre_q == `CCU_PRE_16;
          default: cap_ev = 1'b0;
        endcase
      end

      // channel state; capture and match beat a software pair or flag write
      always @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
          ctrl_q <= `CCU_CTRL_RST;
          pair_q <= 16'h0000;
          pre_q <= 4'h0;
          pin_q <= 1'b0;
          flag_q <= 1'b0;
          trg_q <= 1'b0;
        end else begin
          trg_q <= 1'b0;
          if (I_WR && I_ADDR == OFS_CT) begin
            ctrl_q <= I_WDATA & `CCU_CTRL_MASK;
            pre_q <= 4'h0; // prescaler restarts on any mode write
          end else if (mode == `CCU_M_OFF) begin
            pre_q <= 4'h0;
          end else if (rise) begin
            pre_q <= pre_q + 4'h1;
          end
          if (cap_ev) begin
            pair_q <= tmr_q;
          end else if (I_WR && I_ADDR == OFS_LO) begin
            pair_q[7:0] <= I_WDATA;
          end else if (I_WR && I_ADDR == OFS_HI) begin
            pair_q[15:8] <= I_WDATA;
          end
          if (hit && mode == `CCU_M_CMP_SET)
            pin_q <= 1'b1;
          if (hit && mode == `CCU_M_CMP_CLR)
            pin_q <= 1'b0;
          // zero write clears latch, beats a same-cycle match
          if (I_WR && I_ADDR == OFS_CT && I_WDATA == 8'h00)
            pin_q <= 1'b0;
          if (hit && mode == `CCU_M_CMP_TRIG && !trg_q)
            trg_q <= 1'b1;
          if (cap_ev || hit)
            flag_q <= 1'b1;
          else if (flag_wr[g])
            flag_q <= flag_wval[g];
        end
      end
      assign cap_val[g] = pair_q;
      assign ctrl_val[g] = ctrl_q;
      assign match_set[g] = flag_q;
      assign match_flag_q[g] = flag_q;
      assign trig_q[g] = trg_q;
      always @* O_CMP_PIN[g] = pin_q;
    end
  endgenerate

  // flag-1 bits other than overflow and channel one match are
  // plain storage here, as are enable-one bits without a source; enable two keeps bit 0 only

  // other flag-1 and enable storage
  always @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      flag1_rest_q <= `CCU_FLAG_RST;
      en1_q <= `CCU_FLAG_RST;
      en2_q <= `CCU_FLAG_RST;
    end else begin
      if (I_WR && I_ADDR == `CCU_OFS_FLAG1)
        flag1_rest_q <= I_WDATA & `CCU_FLAG1_REST_MASK;
      if (I_WR && I_ADDR == `CCU_OFS_IRQ_EN1)
        en1_q <= I_WDATA;
      if (I_WR && I_ADDR == `CCU_OFS_CH2_IRQ_EN)
        en2_q <= I_WDATA & `CCU_EN2_MASK;
    end
  end

  // every output below leaves a flop, so the pins see no glitch
  // from the address decode; read data is zero outside the cycle
  // after a read strobe, which keeps a shared read bus quiet
  // the interrupt is a level: it falls one cycle after software
  // clears the flag or drops the enable bit

  // read mux, trigger pulses and interrupt, all registered
  always @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      O_RDATA <= 8'h00;
      O_ADC_START <= 1'b0;
      O_EVT_TRIG <= 2'h0;
      O_IRQ <= 1'b0;
    end else begin
      O_EVT_TRIG <= trig_any;
      O_ADC_START <= trig_q[1] && I_ADC_EN;
      O_IRQ <= (match_set[0] && en1_q[`CCU_F1_CH1_MATCH]) ||
               (match_set[1] && en2_q[`CCU_F2_CH2_MATCH]) ||
               (tmr_ovf_q && en1_q[`CCU_F1_TMR_OVF]);
      O_RDATA <= 8'h00;
      if (I_RD) begin
        case (I_ADDR)
          `CCU_OFS_CH1_LOW: O_RDATA <= cap_val[0][7:0];
          `CCU_OFS_CH1_HIGH: O_RDATA <= cap_val[0][15:8];
          `CCU_OFS_CH1_CTRL: O_RDATA <= ctrl_val[0];
          `CCU_OFS_CH2_LOW: O_RDATA <= cap_val[1][7:0];
          `CCU_OFS_CH2_HIGH: O_RDATA <= cap_val[1][15:8];
          `CCU_OFS_CH2_CTRL: O_RDATA <= ctrl_val[1];
          `CCU_OFS_CH2_FLAG: O_RDATA <= {7'h00, match_flag_q[1]};
          `CCU_OFS_CH2_IRQ_EN: O_RDATA <= en2_q;
          `CCU_OFS_FLAG1: O_RDATA <= flag1_rest_q | {5'h00, match_flag_q[0], 1'b0, tmr_ovf_q};
          `CCU_OFS_IRQ_EN1: O_RDATA <= en1_q;
          `CCU_OFS_TMR_LOW: O_RDATA <= tmr_q[7:0];
          `CCU_OFS_TMR_HIGH: O_RDATA <= tmr_q[15:8];
          `CCU_OFS_TMR_CTRL: O_RDATA <= {7'h00, tmr_run_q};
          default: O_RDATA <= 8'h00; // unmapped reads zero
        endcase
      end
    end
  end

endmodule

// ===== hw/ccu_regs.vh
// Purpose: offsets, fields, reset values and mode codes of the capture/compare unit
// Assumes: byte-wide registers on a plain strobe port
// Notes: all offsets are byte addresses on the register port
`ifndef CCU_REGS_VH
`define CCU_REGS_VH
`define CCU_OFS_CH2_FLAG 8'h0D
`define CCU_OFS_CH1_LOW 8'h15
`define CCU_OFS_CH1_HIGH 8'h16
`define CCU_OFS_CH1_CTRL 8'h17
`define CCU_OFS_CH2_LOW 8'h1B
`define CCU_OFS_CH2_HIGH 8'h1C
`define CCU_OFS_CH2_CTRL 8'h1D
`define CCU_OFS_CH2_IRQ_EN 8'h8D
`define CCU_OFS_FLAG1 8'h0C
`define CCU_OFS_IRQ_EN1 8'h8C
`define CCU_OFS_TMR_LOW 8'h0E
`define CCU_OFS_TMR_HIGH 8'h0F
`define CCU_OFS_TMR_CTRL 8'h10
`define CCU_CTRL_RST 8'h00
`define CCU_FLAG_RST 8'h00
`define CCU_CTRL_MASK 8'h3F
`define CCU_MODE_MSB 3
`define CCU_MODE_LSB 0
`define CCU_F1_TMR_OVF 0
`define CCU_F1_CH1_MATCH 2
`define CCU_F2_CH2_MATCH 0
`define CCU_TCTRL_RUN 0
`define CCU_M_OFF 4'h0
`define CCU_M_CAP_FALL 4'h4
`define CCU_M_CAP_RISE 4'h5
`define CCU_M_CAP_R4 4'h6
`define CCU_M_CAP_R16 4'h7
`define CCU_M_CMP_SET 4'h8
`define CCU_M_CMP_CLR 4'h9
`define CCU_M_CMP_FLAG 4'hA
`define CCU_M_CMP_TRIG 4'hB
`define CCU_PRE_4 4'h3
`define CCU_PRE_16 4'hF
`define CCU_FLAG1_REST_MASK 8'hFA
`define CCU_EN2_MASK 8'h01
`endif

// ===== test/ccu_top_props.sv
// Purpose: port checker for the capture/compare unit
// Assumes: channel modes tracked from control writes
// Notes: bound to ccu_top below
module ccu_props (
  input wire I_REF_CLK, // clock
  input wire I_RST_B, // reset, low
  input wire [7:0] I_ADDR, // address
  input wire [7:0] I_WDATA, // write data
  input wire I_WR, // write strobe
  input wire I_RD, // read strobe
  input wire [1:0] I_CAP_PIN, // pins in
  input wire I_ADC_EN, // converter on
  input wire [7:0] O_RDATA, // read data
  input wire [1:0] O_CMP_PIN, // pins out
  input wire O_ADC_START, // start pulse
  input wire [1:0] O_EVT_TRIG, // triggers
  input wire O_IRQ // interrupt
);
  logic [3:0] m1_q;
  logic [3:0] m2_q;
  default clocking @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // mode copies, so outputs can be tied to their cause
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      m1_q <= 4'h0;
      m2_q <= 4'h0;
    end else if (I_WR) begin
      if (I_ADDR == 8'h17) m1_q <= I_WDATA[3:0];
      if (I_ADDR == 8'h1D) m2_q <= I_WDATA[3:0];
    end
  end
  chk_zero_write: assert property (I_WR && I_ADDR == 8'h17 && I_WDATA == 8'h00 |=> !O_CMP_PIN[0])
    else $error("pin not low after zero write");
  chk_pin_rise: assert property ($rose(O_CMP_PIN[0]) |-> m1_q == 4'h8)
    else $error("pin rose outside set mode");
  chk_pin_fall: assert property ($fell(O_CMP_PIN[0]) |-> m1_q == 4'h9 || m1_q == 4'h0)
    else $error("pin fell outside clear mode");
  chk_trig_mode: assert property (O_EVT_TRIG[0] |-> m1_q == 4'hB)
    else $error("trigger one outside trigger mode");
  chk_trig2_mode: assert property (O_EVT_TRIG[1] |-> m2_q == 4'hB)
    else $error("trigger two outside trigger mode");
  chk_trig_pulse: assert property (O_EVT_TRIG[0] |=> !O_EVT_TRIG[0])
    else $error("trigger longer than one cycle");
  chk_pin_kept: assert property (O_EVT_TRIG != 2'b00 |-> $stable(O_CMP_PIN))
    else $error("pin moved on trigger");
  chk_adc_start: assert property (O_ADC_START |-> O_EVT_TRIG[1])
    else $error("start without trigger two");
  chk_adc_gate: assert property (O_EVT_TRIG[1] && $past(I_ADC_EN) |-> O_ADC_START)
    else $error("no start with converter on");
endmodule
bind ccu_top ccu_props chk_u (.I_REF_CLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .I_CAP_PIN, .I_ADC_EN, .O_RDATA, .O_CMP_PIN, .O_ADC_START, .O_EVT_TRIG, .O_IRQ);

// ===== test/ccu_pin_model.sv
// Purpose: far-side source of capture pin edges
// Assumes: pin idles low between bursts
// Notes: pulses are four cycles high, four low
module ccu_pin_model (
  input wire i_clk, // clock
  input wire i_go, // start burst
  input wire [4:0] i_cnt, // pulses in burst
  output logic o_pin, // capture pin
  output wire o_busy // burst running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q = 8'h00;
  initial o_pin = 1'b0;
  // slow pulses so the two-flop sync never misses one
  always @(posedge i_clk) begin
    if (i_go) left_q <= {i_cnt, 3'b000};
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
    o_pin <= (left_q != 8'h00) && left_q[2];
  end
  assign o_busy = (left_q != 8'h00);
endmodule

// ===== test/capture_compare_unit_test.sv
// Purpose: register-level tests of the capture/compare unit
// Assumes: 4 ns clock, reset held four cycles
// Notes: timer is stopped and preset where a captured value is checked
module capture_compare_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, adc_en = 1'b0, go = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [4:0] cnt = 5'h00;
  logic [1:0] cmp_pin, trig;
  logic adc_start, irq, pin2, busy;
  logic [4:0] ev;
  logic [7:0] regs[5] = '{8'h0D, 8'h17, 8'h1D, 8'h8D, 8'h40};
  logic [7:0] cm[3] = '{8'h08, 8'h09, 8'h08};
  int np[4] = '{1, 1, 4, 16};
  int num_errors = 0, checks_done = 0;
  // channel one pin used as an output; its direction is set outside the block
  ccu_top dut_u (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_CAP_PIN({pin2, 1'b0}), .I_ADC_EN(adc_en), .O_RDATA(rdata),
    .O_CMP_PIN(cmp_pin), .O_ADC_START(adc_start), .O_EVT_TRIG(trig), .O_IRQ(irq));
  ccu_pin_model pin_u (.i_clk(clk), .i_go(go), .i_cnt(cnt), .o_pin(pin2), .o_busy(busy));
  assign ev = {trig, irq, ~cmp_pin[0], cmp_pin[0]};
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  // timer stepped by the bus clock only, never counted asynchronously
  task automatic tmr(input logic [15:0] v, input logic run);
    wr_reg(8'h10, 8'h00);
    wr_reg(8'h0E, v[7:0]);
    wr_reg(8'h0F, v[15:8]);
    wr_reg(8'h10, {7'h00, run});
  endtask
  // bounded wait: a miss counts as a mismatch
  task automatic wait_evt(input int s);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      if (ev[s] === 1'b1) break;
    end
    chk({7'h00, ev[s]}, 8'h01);
  endtask
  task automatic pulses(input int k);
    @(posedge clk);
    cnt <= k[4:0];
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    repeat (200) if (busy !== 1'b0) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i]) rd_reg(regs[i], 8'h00);
    wr_reg(8'h17, 8'hFF);
    rd_reg(8'h17, 8'h3F);
    $display("test regs done");
    wr_reg(8'h15, 8'h20);
    wr_reg(8'h16, 8'h00);
    foreach (cm[i]) begin
      tmr(16'h0000, 1'b1);
      wr_reg(8'h17, cm[i]);
      wait_evt(cm[i] == 8'h08 ? 0 : 1);
      rd_reg(8'h0C, 8'h04);
      wr_reg(8'h0C, 8'h00);
    end
    wr_reg(8'h8C, 8'h04);
    tmr(16'h0000, 1'b1);
    wr_reg(8'h17, 8'h0A);
    wait_evt(2);
    chk({7'h00, cmp_pin[0]}, 8'h01);
    wr_reg(8'h0C, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    wr_reg(8'h8C, 8'h00);
    tmr(16'h0000, 1'b1);
    repeat (50) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    rd_reg(8'h0C, 8'h04);
    wr_reg(8'h17, 8'h00);
    @(negedge clk);
    chk({7'h00, cmp_pin[0]}, 8'h00);
    $display("test compare done");
    wr_reg(8'h0C, 8'h00);
    wr_reg(8'h15, 8'h40);
    wr_reg(8'h16, 8'h01);
    tmr(16'h0000, 1'b1);
    wr_reg(8'h17, 8'h0B);
    wait_evt(3);
    rd_reg(8'h0F, 8'h00);
    rd_reg(8'h0C, 8'h04);
    wait_evt(3);
    wr_reg(8'h17, 8'h00);
    wr_reg(8'h0C, 8'h00);
    wr_reg(8'h1B, 8'h40);
    wr_reg(8'h1C, 8'h00);
    adc_en <= 1'b1;
    tmr(16'h0000, 1'b1);
    wr_reg(8'h1D, 8'h0B);
    wait_evt(4);
    chk({7'h00, adc_start}, 8'h01);
    rd_reg(8'h0D, 8'h01);
    rd_reg(8'h0C, 8'h00);
    @(posedge clk);
    adc_en <= 1'b0;
    wait_evt(4);
    chk({7'h00, adc_start}, 8'h00);
    $display("test trigger done");
    for (int c = 4; c < 8; c++) begin
      tmr({c[7:0], 8'h5A}, 1'b0);
      wr_reg(8'h1C, 8'h00);
      wr_reg(8'h1D, c[7:0]);
      wr_reg(8'h0D, 8'h00);
      if (np[c - 4] > 1) pulses(np[c - 4] - 1);
      rd_reg(8'h0D, 8'h00);
      pulses(1);
      rd_reg(8'h0D, 8'h01);
      rd_reg(8'h1B, 8'h5A);
      rd_reg(8'h1C, c[7:0]);
    end
    $display("test capture done");
    complete_run();
  end
endmodule
